// *** core/dbdl_pkg.sv ***
// Constants for the host-side driver of a double-buffered converter latch.
// Assumes one 200 MHz core clock; the converter pins are plain outputs.
package dbdl_pkg;
   localparam int          DATA_W        = 16;
   localparam int          ADDR_W        = 16;
   localparam int          CLK_MHZ       = 200;
   // ------------------------------------------------------------------
   // Decode window
   // ------------------------------------------------------------------
   localparam logic [15:0] ADDR_LO       = 16'h3000;
   localparam logic [15:0] ADDR_HI       = 16'h3400;
   localparam logic [15:0] TOP_BIT_FLIP  = 16'h8000;
   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int          SKEW_NS       = 100;
   localparam int          SKEW_CYC      = (SKEW_NS * CLK_MHZ + 999) / 1000;
   localparam int          LOW_NS_DEF    = 40;
   localparam int          HIGH_NS_DEF   = 40;
   localparam int          CNT_W         = 16;
   typedef enum logic [2:0] {
      DBDL_IDLE, DBDL_LOAD, DBDL_GAP, DBDL_UPD, DBDL_SETTLE
   } dbdl_state_e;
endpackage : dbdl_pkg

// *** core/dbdl_host.sv ***
// Host controller that drives the converter latch pins from a word stream.
// Assumes the converter pins are driven directly; no read-back exists.
`timescale 1ns/1ps
module dbdl_host #(
   parameter int LOW_CYC    = (dbdl_pkg::LOW_NS_DEF * dbdl_pkg::CLK_MHZ + 999) / 1000,
   parameter int HIGH_CYC   = (dbdl_pkg::HIGH_NS_DEF * dbdl_pkg::CLK_MHZ + 999) / 1000,
   parameter int SETTLE_CYC = 2
) (
   input  wire logic                          i_core_clk,
   input  wire logic                          i_rst_n,
   input  wire logic                          i_valid,
   output logic                               o_ready,
   input  wire logic [dbdl_pkg::DATA_W-1:0]   i_data,
   input  wire logic [dbdl_pkg::ADDR_W-1:0]   i_addr,
   input  wire logic                          i_twos_comp,
   input  wire logic                          i_deferred,
   input  wire logic                          i_update_req,
   output logic [dbdl_pkg::DATA_W-1:0]        o_data,
   output logic                               o_decoded_select_n,
   output logic                               o_first_rank_load_n,
   output logic                               o_converter_update,
   output logic                               o_busy,
   output logic                               o_addr_miss
);
   import dbdl_pkg::*;

   // ------------------------------------------------------------------
   // Two-entry skid buffer
   // ------------------------------------------------------------------
   // Entry holds data, address, deferred flag; stall by the engine loses nothing
   localparam int BW = DATA_W + ADDR_W + 1;
   logic [BW-1:0]      buf_q [2];
   logic [BW-1:0]      next_buf_q [2];
   logic               wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic [1:0]         count, next_count;
   logic               push, pop;

   assign push = i_valid && (count != 2'd2);
   always_comb begin
      next_buf_q  = buf_q;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count  = count;
      if (push) begin
         // Coding chosen when the word is taken, not when it leaves the buffer
         next_buf_q[wr_ptr] = {i_deferred, i_addr,
                               i_twos_comp ? (i_data ^ TOP_BIT_FLIP) : i_data};
         next_wr_ptr        = ~wr_ptr;
      end
      if (pop) begin
         next_rd_ptr = ~rd_ptr;
      end
      next_count = count + {1'b0, push} - {1'b0, pop};
   end
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         buf_q[0] <= '0;
         buf_q[1] <= '0;
         wr_ptr   <= 1'b0;
         rd_ptr   <= 1'b0;
         count    <= 2'd0;
         o_ready  <= 1'b0;
      end else begin
         buf_q    <= next_buf_q;
         wr_ptr   <= next_wr_ptr;
         rd_ptr   <= next_rd_ptr;
         count    <= next_count;
         o_ready  <= (next_count != 2'd2);
      end
   end

   // ------------------------------------------------------------------
   // Update request sync (may come from another domain)
   // ------------------------------------------------------------------
   logic upd_s1, upd_s2, upd_s3;
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         upd_s1 <= 1'b0;
         upd_s2 <= 1'b0;
         upd_s3 <= 1'b0;
      end else begin
         upd_s1 <= i_update_req;
         upd_s2 <= upd_s1;
         upd_s3 <= upd_s2;
      end
   end

   // ------------------------------------------------------------------
   // Pin sequencer
   // ------------------------------------------------------------------
   dbdl_state_e        state, next_state;
   logic [CNT_W-1:0]   cnt, next_cnt;
   logic [DATA_W-1:0]  next_data;
   logic               next_sel_n, next_load_n, next_upd, next_miss;
   logic               upd_pend, next_upd_pend;
   logic [BW-1:0]      head;
   logic [DATA_W-1:0]  head_data;
   logic [ADDR_W-1:0]  head_addr;
   logic               head_def, hit;

   assign head      = buf_q[rd_ptr];
   assign head_data = head[DATA_W-1:0];
   assign head_addr = head[DATA_W +: ADDR_W];
   assign head_def  = head[BW-1];
   assign hit       = (head_addr >= ADDR_LO) && (head_addr <= ADDR_HI);
   assign pop       = (state == DBDL_IDLE) && (count != 2'd0) && !upd_pend;

   always_comb begin
      next_state    = state;
      next_cnt      = (cnt != '0) ? cnt - 1'b1 : cnt;
      next_data     = o_data;
      next_sel_n    = o_decoded_select_n;
      next_load_n   = o_first_rank_load_n;
      next_upd      = o_converter_update;
      next_miss     = 1'b0;
      next_upd_pend = upd_pend || (upd_s2 && !upd_s3);
      case (state)
         DBDL_IDLE: begin
            if (upd_pend) begin
               // Shared update pulse refreshes every converter at once
               next_upd      = 1'b1;
               next_upd_pend = 1'b0;
               next_cnt      = CNT_W'(HIGH_CYC);
               next_state    = DBDL_UPD;
            end else if (pop && !hit) begin
               next_miss = 1'b1;
            end else if (pop) begin
               // Positive-true data; flip top bit for two's complement
               next_data   = head_data;
               next_sel_n  = 1'b0;
               next_load_n = 1'b0;
               next_cnt    = CNT_W'(LOW_CYC);
               next_upd_pend = next_upd_pend || !head_def;
               next_state  = DBDL_LOAD;
            end
         end
         DBDL_LOAD: begin
            if (cnt == '0) begin
               // Strobe rises first so data hold is met against the select
               next_load_n = 1'b1;
               next_cnt    = CNT_W'(SKEW_CYC);
               next_state  = DBDL_GAP;
            end
         end
         DBDL_GAP: begin
            next_sel_n = 1'b1;
            if (cnt == '0) begin
               next_state = DBDL_IDLE;
            end
         end
         DBDL_UPD: begin
            if (cnt == '0) begin
               next_upd   = 1'b0;
               next_cnt   = CNT_W'(SETTLE_CYC);
               next_state = DBDL_SETTLE;
            end
         end
         DBDL_SETTLE: begin
            if (cnt == '0) begin
               next_state = DBDL_IDLE;
            end
         end
         default: begin
            next_state = DBDL_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         // Idle pins: deselected, load high, update low holds code
         state               <= DBDL_IDLE;
         cnt                 <= '0;
         upd_pend            <= 1'b0;
         o_data              <= '0;
         o_decoded_select_n  <= 1'b1;
         o_first_rank_load_n <= 1'b1;
         o_converter_update  <= 1'b0;
         o_busy              <= 1'b0;
         o_addr_miss         <= 1'b0;
      end else begin
         state               <= next_state;
         cnt                 <= next_cnt;
         upd_pend            <= next_upd_pend;
         o_data              <= next_data;
         o_decoded_select_n  <= next_sel_n;
         o_first_rank_load_n <= next_load_n;
         o_converter_update  <= next_upd;
         o_busy              <= (next_state != DBDL_IDLE);
         o_addr_miss         <= next_miss;
      end
   end
endmodule : dbdl_host

// *** tb/dbdl_host_monitor.sv ***
// Checker for the converter latch host driver.
// Assumes it is bound to dbdl_host and sees only its ports.
`timescale 1ns/1ps
module dbdl_host_monitor (
   input wire logic                        i_core_clk,
   input wire logic                        i_rst_n,
   input wire logic [dbdl_pkg::DATA_W-1:0] o_data,
   input wire logic                        o_decoded_select_n,
   input wire logic                        o_first_rank_load_n,
   input wire logic                        o_converter_update
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   // ----
   // Pin timing
   // ----
   property p_gap; $rose(o_converter_update) |-> $past(o_first_rank_load_n, 20); endproperty
   a_gap: assert property (p_gap) else $error("update too soon after load");
   property p_excl; o_converter_update |-> o_first_rank_load_n; endproperty
   a_excl: assert property (p_excl) else $error("update during load");
   property p_cap; $rose(o_first_rank_load_n) |-> !o_decoded_select_n; endproperty
   a_cap: assert property (p_cap) else $error("select left before load");
   property p_sel; !o_first_rank_load_n |-> !o_decoded_select_n; endproperty
   a_sel: assert property (p_sel) else $error("load without select");
   property p_rel; $rose(o_first_rank_load_n) |=> $rose(o_decoded_select_n); endproperty
   a_rel: assert property (p_rel) else $error("select not released");
   property p_low; $fell(o_first_rank_load_n) |=> !o_first_rank_load_n [*8]; endproperty
   a_low: assert property (p_low) else $error("load pulse too short");
   property p_hold; !o_first_rank_load_n && $past(!o_first_rank_load_n) |-> $stable(o_data);
   endproperty
   a_hold: assert property (p_hold) else $error("data moved under load");
   property p_upw; $rose(o_converter_update) |=> o_converter_update [*8]; endproperty
   a_upw: assert property (p_upw) else $error("update pulse too short");
   c_upd: cover property ($rose(o_converter_update));
   c_load: cover property ($fell(o_first_rank_load_n));
   c_idle: cover property ($fell(o_converter_update) ##1 o_first_rank_load_n);
endmodule : dbdl_host_monitor
bind dbdl_host dbdl_host_monitor i_mon (.i_core_clk, .i_rst_n, .o_data, .o_decoded_select_n,
   .o_first_rank_load_n, .o_converter_update);

// *** tb/dbdl_conv_model.sv ***
// Behavioural two-rank converter latch facing the host driver.
// Assumes level-sensitive pins straight from the host outputs.
`timescale 1ns/1ps
module dbdl_conv_model (
   input wire logic [dbdl_pkg::DATA_W-1:0] i_data,
   input wire logic                        i_decoded_select_n,
   input wire logic                        i_first_rank_load_n,
   input wire logic                        i_converter_update,
   output logic [dbdl_pkg::DATA_W-1:0]     o_rank1,
   output logic [dbdl_pkg::DATA_W-1:0]     o_code
);
   import dbdl_pkg::*;
   // No reset, so both ranks start unknown
   always @* if (!i_decoded_select_n && !i_first_rank_load_n) o_rank1 = i_data;
   always @* if (i_converter_update) o_code = o_rank1;
endmodule : dbdl_conv_model

// *** tb/tb_double_buffered_dac_latch.sv ***
// Self-checking bench for the converter latch host driver.
// Assumes the design package and the latch model are compiled first.
`timescale 1ns/1ps
module tb_double_buffered_dac_latch;
   import dbdl_pkg::*;
   logic        clk = 0, rst_n = 0, valid = 0, tc = 0, dfr = 0, upq = 0, pl = 1, pu = 0;
   logic [15:0] din = 0, addr = 0, last;
   wire  [15:0] dout, rank1, code;
   wire         ready, sel_n, load_n, upd, busy, miss;
   int          fails = 0, tests_run = 0, cyc = 0, seed = 32'hb8ec, nmiss = 0, nexp = 0, k;
   logic [15:0] q[$];
   logic [15:0] ta[4] = '{16'h3000, 16'h3400, 16'h2fff, 16'h3401};
   logic [15:0] td[4] = '{16'h0000, 16'hffff, 16'h8000, 16'h7fff};
   dbdl_host i_dbdl_host (.i_core_clk(clk), .i_rst_n(rst_n), .i_valid(valid), .o_ready(ready),
      .i_data(din), .i_addr(addr), .i_twos_comp(tc), .i_deferred(dfr), .i_update_req(upq),
      .o_data(dout), .o_decoded_select_n(sel_n), .o_first_rank_load_n(load_n),
      .o_converter_update(upd), .o_busy(busy), .o_addr_miss(miss));
   dbdl_conv_model i_dbdl_conv_model (.i_data(dout), .i_decoded_select_n(sel_n),
      .i_first_rank_load_n(load_n), .i_converter_update(upd), .o_rank1(rank1), .o_code(code));
   initial begin
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic give_verdict;
      if (fails == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : give_verdict
   // ----
   // Watch the latch pins
   // ----
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         fails++;
         give_verdict();
      end
      if (miss === 1'b1) nmiss++;
      if (load_n === 1'b1 && pl === 1'b0) begin
         last = (q.size() > 0) ? q.pop_front() : 16'hxxxx;
         chk("rank1", last, rank1);
      end
      if (upd === 1'b0 && pu === 1'b1) chk("code", last, code);
      pl = load_n;
      pu = upd;
   end
   // ----
   // Stimulus
   // ----
   initial begin
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(negedge clk);
         valid = 1'b1;
         din = (i >= 4 && i < 8) ? td[i-4] : 16'($random(seed));
         tc = 1'($random(seed));
         dfr = (i % 4 == 3);
         upq = i[3];
         addr = (i < 4) ? ta[i] : 16'h3000 + (16'($random(seed)) & 16'h03ff);
         do @(posedge clk); while (ready !== 1'b1);
         if (addr >= ADDR_LO && addr <= ADDR_HI) q.push_back(tc ? din ^ TOP_BIT_FLIP : din);
         else nexp++;
      end
      @(negedge clk);
      valid = 1'b0;
      for (k = 0; k < 3000 && (q.size() > 0 || busy !== 1'b0); k++) @(negedge clk);
      upq = 1'b1;
      for (k = 0; k < 100 && busy !== 1'b1; k++) @(negedge clk);
      for (k = 0; k < 100 && busy !== 1'b0; k++) @(negedge clk);
      chk("misses", 16'(nexp), 16'(nmiss));
      chk("final", last, code);
      give_verdict();
   end
endmodule : tb_double_buffered_dac_latch
